// ### src/interrupt_priority_controller.sv
// top: enable, four-level priority, polling and vectoring of ten interrupt sources
// Operation
// - global enable bit seven gates all servicing
// - level from low bit and high bit
// - equal level resolved by fixed polling rank
// - ext zero vector 0003H, bit0, rank1
// - timer zero vector 000BH, bit1, rank3
// - ext one vector 0013H, bit2, rank4
// - timer one vector 001BH, bit3, rank5
// - uart vector 0023H, bit4, rank6
// - primary i2c vector 002BH, bit5, rank2
// - counter array vector 0033H, bit6, rank8
// - timer two vector 003BH, en1 bit0, rank7
// - secondary i2c vector 0043H, rank10
// - spi vector 004BH, en1 bit2, rank9
// - high registers byte only; reset zero
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_controller (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // register bus
  input  wire irq_prio_pkg::avmm_req_t bus_req,
  output irq_prio_pkg::avmm_rsp_t      bus_rsp,
  // request flags from peripherals
  input  wire logic                    ext_zero_flag,
  input  wire logic                    timer_zero_overflow_flag,
  input  wire logic                    ext_one_flag,
  input  wire logic                    timer_one_overflow_flag,
  input  wire logic                    uart_transmit_flag,
  input  wire logic                    uart_receive_flag,
  input  wire logic                    i2c_primary_req,
  input  wire logic                    counter_array_overflow_flag,
  input  wire logic [4:0]              module_compare_flag,
  input  wire logic                    timer_two_overflow_flag,
  input  wire logic                    timer_two_external_flag,
  input  wire logic                    i2c_secondary_req,
  input  wire logic                    spi_done_flag,
  // cpu core handshake
  input  wire logic                    irq_ack,
  input  wire logic                    irq_return,
  output irq_prio_pkg::irq_out_t       irq_out
);
  import irq_prio_pkg::*;

  // registers
  logic [7:0]       en0_r, en1_r, low0_r, low1_r, high0_r, high1_r;
  logic [LVL_N-1:0] active_r;      // levels currently in service
  irq_out_t         irq_out_r;     // registered request to the core
  avmm_rsp_t        rsp_r;         // registered bus answer
  logic             ack_pend_r;    // one wait cycle before answering

  // bus decode
  wire [7:0] idx      = bus_req.address[ADDR_W-1:2];
  wire       acc      = (bus_req.read | bus_req.write) & ~ack_pend_r;
  // write lands at the edge where the master sees waitrequest low
  wire       wr       = bus_req.write & ack_pend_r & bus_req.byteenable[0];
  wire [7:0] wbyte    = bus_req.writedata[7:0];
  wire       wr_en0   = wr & (idx == IDX_IRQ_EN_0);
  wire       wr_en1   = wr & (idx == IDX_IRQ_EN_1);
  wire       wr_low0  = wr & (idx == IDX_PRIO_LOW_0);
  wire       wr_low1  = wr & (idx == IDX_PRIO_LOW_1);
  wire       wr_high0 = wr & (idx == IDX_PRIO_HIGH_0);
  wire       wr_high1 = wr & (idx == IDX_PRIO_HIGH_1);
  wire       wr_bop   = wr & (idx == IDX_BIT_OP);
  wire       wr_reti  = wr & (idx == IDX_RETI);

  // single-bit operation fields
  wire [2:0] bop_bit = wbyte[BOP_BIT_LSB +: 3];
  wire [2:0] bop_sel = wbyte[BOP_SEL_LSB +: 3];
  wire       bop_val = wbyte[BOP_VAL_BIT];

  // apply one bit to a byte
  function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] b, input logic x);
    logic [7:0] r;
    r    = v;
    r[b] = x;
    return r;
  endfunction

  // next register values; bit ops only reach enable and low regs
  wire [7:0] en0_nxt  = wr_en0 ? wbyte :
                        (wr_bop && bop_sel == BSEL_EN0) ? set_bit(en0_r, bop_bit, bop_val) : en0_r;
  wire [7:0] en1_nxt  = wr_en1 ? (wbyte & EN1_MASK) :
                        (wr_bop && bop_sel == BSEL_EN1) ? (set_bit(en1_r, bop_bit, bop_val) & EN1_MASK) : en1_r;
  wire [7:0] low0_nxt = wr_low0 ? wbyte :
                        (wr_bop && bop_sel == BSEL_LOW0) ? set_bit(low0_r, bop_bit, bop_val) : low0_r;
  wire [7:0] low1_nxt = wr_low1 ? (wbyte & PRIO1_MASK) :
                        (wr_bop && bop_sel == BSEL_LOW1) ? (set_bit(low1_r, bop_bit, bop_val) & PRIO1_MASK) : low1_r;
  wire [7:0] high0_nxt = wr_high0 ? wbyte : high0_r;
  wire [7:0] high1_nxt = wr_high1 ? (wbyte & PRIO1_MASK) : high1_r;

  // raw requests, indexed by table order
  wire src_vec_t raw_req = {spi_done_flag,
                            i2c_secondary_req,
                            timer_two_overflow_flag | timer_two_external_flag,
                            counter_array_overflow_flag | (|module_compare_flag),
                            i2c_primary_req,
                            uart_transmit_flag | uart_receive_flag,
                            timer_one_overflow_flag,
                            ext_one_flag,
                            timer_zero_overflow_flag,
                            ext_zero_flag};

  // per-source enable and priority bits
  wire src_vec_t src_en   = {en1_r[2:0], en0_r[6:0]};
  wire src_vec_t src_low  = {low1_r[1:0], low0_r};
  wire src_vec_t src_high = {high1_r[1:0], high0_r};
  wire           g_en     = en0_r[GLOBAL_EN_BIT];
  wire src_vec_t pending  = raw_req & src_en & {NSRC{g_en}};

  // candidates split by level, 3 highest
  src_vec_t lvl_cand [LVL_N];
  always_comb begin
    for (int l = 0; l < LVL_N; l++) begin
      for (int s = 0; s < NSRC; s++) begin
        lvl_cand[l][s] = pending[s] && ({src_high[s], src_low[s]} == l[1:0]);
      end
    end
  end

  // one polling-rank selector per level
  logic     lvl_found [LVL_N];
  src_idx_t lvl_pick  [LVL_N];
  genvar gl;
  generate
    for (gl = 0; gl < LVL_N; gl++) begin : g_lvl
      prio_select u_sel (
        .cand  (lvl_cand[gl]),
        .found (lvl_found[gl]),
        .pick  (lvl_pick[gl])
      );
    end
  endgenerate

  // highest level with a pending source, then its best rank
  logic     win_found;
  level_t   win_lvl;
  src_idx_t win_src;
  always_comb begin
    win_found = 1'b0;
    win_lvl   = '0;
    win_src   = '0;
    for (int l = 0; l < LVL_N; l++) begin
      if (lvl_found[l]) begin
        win_found = 1'b1;
        win_lvl   = l[1:0];
        win_src   = lvl_pick[l];
      end
    end
  end

  // highest level now in service; preempt only above it
  logic   any_active;
  level_t act_lvl;
  always_comb begin
    any_active = 1'b0;
    act_lvl    = '0;
    for (int l = 0; l < LVL_N; l++) begin
      if (active_r[l]) begin
        any_active = 1'b1;
        act_lvl    = l[1:0];
      end
    end
  end
  wire can_take = win_found && (!any_active || win_lvl > act_lvl);

  // acknowledge marks level active, return clears top level
  wire [LVL_N-1:0] ack_bit  = (irq_ack && irq_out_r.valid) ? (LVL_N'(1) << irq_out_r.level) : '0;
  wire [LVL_N-1:0] ret_bit  = ((irq_return || wr_reti) && any_active) ? (LVL_N'(1) << act_lvl) : '0;
  wire [LVL_N-1:0] active_nxt = (active_r & ~ret_bit) | ack_bit;

  // request presented to the core, dropped on ack
  irq_out_t irq_nxt;
  always_comb begin
    irq_nxt        = '0;
    irq_nxt.valid  = can_take && !(irq_ack && irq_out_r.valid);
    irq_nxt.vector = VEC_TAB[win_src];
    irq_nxt.source = win_src;
    irq_nxt.level  = win_lvl;
  end

  // read mux, reserved bits read zero, unmapped reads zero
  logic [7:0] rbyte;
  always_comb begin
    case (idx)
      IDX_IRQ_EN_0:    rbyte = en0_r;
      IDX_IRQ_EN_1:    rbyte = en1_r;
      IDX_PRIO_LOW_0:  rbyte = low0_r;
      IDX_PRIO_LOW_1:  rbyte = low1_r;
      IDX_PRIO_HIGH_0: rbyte = high0_r;
      IDX_PRIO_HIGH_1: rbyte = high1_r;
      IDX_STATUS:      rbyte = {win_found, irq_out_r.valid, 2'h0, active_r};
      default:         rbyte = RESET_BYTE;
    endcase
  end

  // configuration registers, all clear at reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en0_r   <= RESET_BYTE;
      en1_r   <= RESET_BYTE;
      low0_r  <= RESET_BYTE;
      low1_r  <= RESET_BYTE;
      high0_r <= RESET_BYTE;
      high1_r <= RESET_BYTE;
    end else begin
      en0_r   <= en0_nxt;
      en1_r   <= en1_nxt;
      low0_r  <= low0_nxt;
      low1_r  <= low1_nxt;
      high0_r <= high0_nxt;
      high1_r <= high1_nxt;
    end
  end

  // service state and request output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_r  <= '0;
      irq_out_r <= '0;
    end else begin
      active_r  <= active_nxt;
      irq_out_r <= irq_nxt;
    end
  end

  // bus answer: waitrequest low one cycle after the request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_pend_r <= 1'b0;
      rsp_r      <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
    end else begin
      ack_pend_r        <= acc;
      rsp_r.waitrequest <= ~acc;
      rsp_r.readdata    <= {24'h00_0000, rbyte};
    end
  end

  assign bus_rsp = rsp_r;
  assign irq_out = irq_out_r;
endmodule
`default_nettype wire

// ### src/irq_prio_pkg.sv
// package: register map, source table and bus types for the interrupt priority controller
package irq_prio_pkg;

  // register indexes on the avalon bus, taken from address bits [9:2] (printed offsets, not all multiples of four)
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_PRIO_LOW_1   = 8'h91;
  localparam logic [7:0] IDX_PRIO_HIGH_1  = 8'h92;
  localparam logic [7:0] IDX_IRQ_EN_0     = 8'hA8;
  localparam logic [7:0] IDX_PRIO_HIGH_0  = 8'hB7;
  localparam logic [7:0] IDX_PRIO_LOW_0   = 8'hB8;
  localparam logic [7:0] IDX_IRQ_EN_1     = 8'hE8;
  // own registers: bit-operation port and status/control
  localparam logic [7:0] IDX_BIT_OP       = 8'hF0;
  localparam logic [7:0] IDX_STATUS       = 8'hF1;
  localparam logic [7:0] IDX_RETI         = 8'hF2;

  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam int         GLOBAL_EN_BIT    = 7;
  localparam logic [7:0] EN1_MASK         = 8'h07;
  localparam logic [7:0] PRIO1_MASK       = 8'h03;

  // bit-op register layout: [2:0] bit, [5:3] register select, [6] value
  localparam int BOP_BIT_LSB = 0;
  localparam int BOP_SEL_LSB = 3;
  localparam int BOP_VAL_BIT = 6;
  localparam logic [2:0] BSEL_EN0  = 3'h0;
  localparam logic [2:0] BSEL_EN1  = 3'h1;
  localparam logic [2:0] BSEL_LOW0 = 3'h2;
  localparam logic [2:0] BSEL_LOW1 = 3'h3;

  // sources, numbered by table order
  localparam int NSRC  = 10;
  localparam int SRC_W = 4;
  localparam int LVL_N = 4;
  typedef logic [NSRC-1:0]  src_vec_t;
  typedef logic [15:0]      vector_t;
  typedef logic [SRC_W-1:0] src_idx_t;
  typedef logic [1:0]       level_t;

  // vector address per source
  localparam vector_t VEC_TAB [NSRC] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
                                         16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h004B};
  // polling rank per source, 1 served first
  localparam src_idx_t RANK_TAB [NSRC] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6,
                                           4'h2, 4'h8, 4'h7, 4'hA, 4'h9};
  // sources ordered by rank (lowest rank first)
  localparam src_idx_t POLL_ORDER [NSRC] = '{4'h0, 4'h5, 4'h1, 4'h2, 4'h3,
                                             4'h4, 4'h7, 4'h6, 4'h9, 4'h8};

  // avalon-mm slave request and answer
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avmm_rsp_t;

  // request to the cpu core
  typedef struct packed {
    logic     valid;
    vector_t  vector;
    src_idx_t source;
    level_t   level;
  } irq_out_t;

endpackage

// ### src/prio_select.sv
// leaf: picks the best pending source among the enabled ones for one level
`timescale 1ns/1ns
`default_nettype none
module prio_select (
  // candidates
  input  wire irq_prio_pkg::src_vec_t  cand,
  // result
  output logic                         found,
  output irq_prio_pkg::src_idx_t       pick
);
  import irq_prio_pkg::*;

  // walk sources in reverse polling order, last hit (lowest rank) wins
  always_comb begin
    found = 1'b0;
    pick  = '0;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (cand[POLL_ORDER[k]]) begin
        found = 1'b1;
        pick  = POLL_ORDER[k];
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/irq_core_model.sv
// partner: cpu core model that accepts requests and ends routines
`timescale 1ns/1ns
`default_nettype none
module irq_core_model (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // controller side
  input  wire irq_prio_pkg::irq_out_t irq_out,
  output logic                        irq_ack,
  output logic                        irq_return,
  // bench control and record
  input  wire logic                   serve,
  input  wire logic                   slow,
  input  wire logic                   fin,
  output irq_prio_pkg::vector_t       taken_vec,
  output logic [7:0]                  taken_cnt
);
  import irq_prio_pkg::*;
  logic [1:0] wait_r; // cycles spent before accepting
  // accept after zero or two idle cycles, return when told
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_ack    <= 1'b0;
      irq_return <= 1'b0;
      wait_r     <= 2'h0;
      taken_vec  <= 16'h0000;
      taken_cnt  <= 8'h00;
    end else begin
      irq_return <= fin;
      irq_ack    <= 1'b0;
      wait_r     <= 2'h0;
      if (serve && irq_out.valid && !irq_ack) begin
        wait_r <= wait_r + 2'h1;
        if (wait_r == {slow, 1'b0}) begin
          irq_ack   <= 1'b1;
          taken_vec <= irq_out.vector;
          taken_cnt <= taken_cnt + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/interrupt_priority_controller_checker.sv
// checker: port-level assertions of the interrupt priority controller
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_controller_checker (
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    rst,
  // register bus
  input wire irq_prio_pkg::avmm_req_t bus_req,
  input wire irq_prio_pkg::avmm_rsp_t bus_rsp,
  // core handshake
  input wire logic                    irq_ack,
  input wire logic                    irq_return,
  input wire irq_prio_pkg::irq_out_t  irq_out
);
  import irq_prio_pkg::*;
  logic   ge_r;  // shadow of the global enable
  logic   srv_r; // a routine is in service
  level_t lvl_r; // level of that routine
  wire    en0_wr = bus_req.write && !bus_rsp.waitrequest && bus_req.byteenable[0]
                   && bus_req.address == {IDX_IRQ_EN_0, 2'b00};
  // follow enable writes and the level being served
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ge_r  <= 1'b0;
      srv_r <= 1'b0;
      lvl_r <= 2'h0;
    end else begin
      if (en0_wr)
        ge_r <= bus_req.writedata[GLOBAL_EN_BIT];
      if (irq_ack && irq_out.valid) begin
        srv_r <= 1'b1;
        lvl_r <= irq_out.level;
      end else if (irq_return)
        srv_r <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_GLOBAL_GATE: assert property (!ge_r && $past(!ge_r) |-> !irq_out.valid)
    else $error("request with global enable clear");
  AST_VECTOR_MAP: assert property (irq_out.valid |-> irq_out.source < NSRC
    && irq_out.vector == VEC_TAB[irq_out.source]) else $error("vector does not match source");
  AST_ACK_DROP: assert property (irq_ack && irq_out.valid |=> !irq_out.valid)
    else $error("request stays after acceptance");
  AST_NO_EQUAL_PREEMPT: assert property (srv_r && irq_out.valid |-> irq_out.level > lvl_r)
    else $error("request not above level in service");
  AST_WAIT_ONE: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
    else $error("answer longer than one cycle");
  AST_ANSWER: assert property ($rose(bus_req.read || bus_req.write) |=> !bus_rsp.waitrequest)
    else $error("answer late");
  AST_UPPER_ZERO: assert property (!bus_rsp.waitrequest && bus_req.read |-> bus_rsp.readdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  AST_RESET_IDLE: assert property ($past(rst) |-> bus_rsp.waitrequest && !irq_out.valid)
    else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ### verif/interrupt_priority_controller_tb.sv
// testbench: table and hand-written checks of the interrupt priority controller
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_controller_tb;
  import irq_prio_pkg::*;
  // one row: enable, priorities, flags, expected vector (0 = none)
  typedef struct packed {
    logic [7:0]  e0;
    logic [7:0]  l0;
    logic [7:0]  h0;
    logic [7:0]  p1;
    logic [12:0] f;
    vector_t     vec;
  } row_t;
  localparam row_t ROWS [19] = '{
    '{8'hFF,8'h00,8'h00,8'h00,13'h3FF,16'h0003}, '{8'hFF,8'h00,8'h00,8'h00,13'h3FE,16'h002B},
    '{8'hFF,8'h00,8'h00,8'h00,13'h3DE,16'h000B}, '{8'hFF,8'h00,8'h00,8'h00,13'h3DC,16'h0013},
    '{8'hFF,8'h00,8'h00,8'h00,13'h3D8,16'h001B}, '{8'hFF,8'h00,8'h00,8'h00,13'h3D0,16'h0023},
    '{8'hFF,8'h00,8'h00,8'h00,13'h3C0,16'h003B}, '{8'hFF,8'h00,8'h00,8'h00,13'h340,16'h0033},
    '{8'hFF,8'h00,8'h00,8'h00,13'h300,16'h004B}, '{8'hFF,8'h00,8'h00,8'h00,13'h100,16'h0043},
    '{8'hFF,8'h00,8'h00,8'h00,13'h400,16'h0023}, '{8'hFF,8'h00,8'h00,8'h00,13'h800,16'h0033},
    '{8'hFF,8'h00,8'h00,8'h00,13'h1000,16'h003B}, '{8'hFF,8'h80,8'h00,8'h00,13'h3FF,16'h003B},
    '{8'hFF,8'h80,8'h04,8'h00,13'h3FF,16'h0013}, '{8'hFF,8'h80,8'h04,8'h01,13'h3FF,16'h0043},
    '{8'hFF,8'h00,8'h00,8'h02,13'h3FF,16'h004B}, '{8'h7F,8'h00,8'h00,8'h00,13'h1FFF,16'h0000},
    '{8'h81,8'h00,8'h00,8'h00,13'h07E,16'h0000}};
  localparam logic [7:0] RIDX [6] = '{8'h91, 8'h92, 8'hA8, 8'hB7, 8'hB8, 8'hE8};
  localparam logic [7:0] RMSK [6] = '{8'h03, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h07};
  logic        core_clk, rst, irq_ack, irq_return, serve, slow, fin;
  avmm_req_t   bus_req;
  avmm_rsp_t   bus_rsp;
  irq_out_t    irq_out;
  logic [12:0] flg;       // source flags, bits 0-9 in table order, bits 10-12 second flags of uart, counter array and timer two
  vector_t     taken_vec;
  logic [7:0]  taken_cnt, q;
  int          err_count, checks_done;
  interrupt_priority_controller i_dut (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .ext_zero_flag(flg[0]), .timer_zero_overflow_flag(flg[1]),
    .ext_one_flag(flg[2]), .timer_one_overflow_flag(flg[3]), .uart_transmit_flag(flg[4]),
    .uart_receive_flag(flg[10]), .i2c_primary_req(flg[5]), .counter_array_overflow_flag(flg[6]),
    .module_compare_flag({flg[11], 4'h0}), .timer_two_overflow_flag(flg[7]),
    .timer_two_external_flag(flg[12]), .i2c_secondary_req(flg[8]), .spi_done_flag(flg[9]),
    .irq_ack(irq_ack), .irq_return(irq_return), .irq_out(irq_out));
  irq_core_model i_core (.core_clk(core_clk), .rst(rst), .irq_out(irq_out), .irq_ack(irq_ack),
    .irq_return(irq_return), .serve(serve), .slow(slow), .fin(fin), .taken_vec(taken_vec),
    .taken_cnt(taken_cnt));
  // compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    bus_req.address <= {idx, 2'b00};
    bus_req.write <= wr;
    bus_req.read <= !wr;
    bus_req.writedata <= {24'h0, d};
    do begin
      @(negedge core_clk);
      n++;
    end while (bus_rsp.waitrequest !== 1'b0 && n < 20);
    q = bus_rsp.readdata[7:0];
    @(posedge core_clk);
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
    @(posedge core_clk);
    if (n >= 20) chk("bus", 16'h0000, 16'hFFFF);
  endtask
  // wait for the core model to accept a given count
  task automatic wait_cnt(input logic [7:0] n);
    int k;
    k = 0;
    while (taken_cnt !== n && k < 40) begin
      @(posedge core_clk);
      k++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    bus_req = '0;
    bus_req.byteenable = 4'hF;
    {flg, serve, slow, fin, err_count, checks_done} = '0;
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    xfer(IDX_IRQ_EN_1, 1'b1, 8'h07);
    foreach (ROWS[i]) begin
      xfer(IDX_IRQ_EN_0, 1'b1, ROWS[i].e0);
      xfer(IDX_PRIO_LOW_0, 1'b1, ROWS[i].l0);
      xfer(IDX_PRIO_HIGH_0, 1'b1, ROWS[i].h0);
      xfer(IDX_PRIO_LOW_1, 1'b1, ROWS[i].p1);
      xfer(IDX_PRIO_HIGH_1, 1'b1, ROWS[i].p1);
      flg <= ROWS[i].f;
      repeat (3) @(posedge core_clk);
      chk("valid", {15'h0, ROWS[i].vec != 16'h0}, {15'h0, irq_out.valid});
      chk("vector", ROWS[i].vec, irq_out.valid === 1'b1 ? irq_out.vector : 16'h0);
      chk("source", ROWS[i].vec, irq_out.valid === 1'b1 ? VEC_TAB[irq_out.source] : 16'h0);
    end
    // second reset in mid-run, then reset values and masks
    flg <= '0;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (RIDX[i]) begin
      xfer(RIDX[i], 1'b0, 8'h00);
      chk("reset", 16'h0000, {8'h00, q});
      xfer(RIDX[i], 1'b1, 8'hFF);
      xfer(RIDX[i], 1'b0, 8'h00);
      chk("mask", {8'h00, RMSK[i]}, {8'h00, q});
    end
    xfer(8'h10, 1'b1, 8'hFF);
    xfer(8'h10, 1'b0, 8'h00);
    chk("unmapped", 16'h0000, {8'h00, q});
    xfer(IDX_IRQ_EN_0, 1'b1, 8'h00);
    xfer(IDX_BIT_OP, 1'b1, 8'h44);
    xfer(IDX_IRQ_EN_0, 1'b0, 8'h00);
    chk("bit set", 16'h0010, {8'h00, q});
    // nesting: equal level waits, higher level preempts
    xfer(IDX_IRQ_EN_0, 1'b1, 8'hFF);
    xfer(IDX_PRIO_LOW_0, 1'b1, 8'h00);
    xfer(IDX_PRIO_HIGH_0, 1'b1, 8'h00);
    xfer(IDX_PRIO_LOW_1, 1'b1, 8'h02);
    xfer(IDX_PRIO_HIGH_1, 1'b1, 8'h02);
    serve <= 1'b1;
    flg <= 13'h001;
    wait_cnt(8'h01);
    chk("first", 16'h0003, taken_vec);
    flg <= 13'h003;
    repeat (6) @(posedge core_clk);
    chk("count", 16'h0001, {8'h00, taken_cnt});
    slow <= 1'b1;
    flg <= 13'h203;
    wait_cnt(8'h02);
    chk("preempt", 16'h004B, taken_vec);
    flg <= 13'h002;
    repeat (2) begin
      fin <= 1'b1;
      @(posedge core_clk);
      fin <= 1'b0;
      @(posedge core_clk);
    end
    wait_cnt(8'h03);
    chk("resumed", 16'h000B, taken_vec);
    tally_and_finish();
  end
endmodule
bind interrupt_priority_controller interrupt_priority_controller_checker i_chk (.core_clk(core_clk),
  .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp), .irq_ack(irq_ack), .irq_return(irq_return),
  .irq_out(irq_out));
`default_nettype wire
